// File: logic/bors_ctl_if.sv
`timescale 1ns/1ps
interface bors_ctl_if;
	logic                           start;
	logic [bors_pkg::CNT_W-1:0]     load;
	logic                           done;
	modport timer (input start, input load, output done);
	modport user  (output start, output load, input done);
endinterface : bors_ctl_if

// File: logic/bors_pkg.sv
package bors_pkg;
	// oscillator selection codes (initial_osc_select)
	localparam logic [2:0] OSC_SEL_FRC     = 3'h0;
	localparam logic [2:0] OSC_SEL_FRC_PLL = 3'h1;
	localparam logic [2:0] OSC_SEL_PRI     = 3'h2;
	localparam logic [2:0] OSC_SEL_PRI_PLL = 3'h3;
	// primary oscillator modes (primary_osc_mode)
	localparam logic [1:0] POSC_EC         = 2'h0;
	localparam logic [1:0] POSC_XT         = 2'h1;
	localparam logic [1:0] POSC_HS         = 2'h2;
	localparam logic [1:0] POSC_OFF        = 2'h3;
	// field positions
	localparam int         OSC_LOCK_BIT    = 5;
	localparam int         RST_BROWNOUT_BIT = 1;
	// reset values
	localparam logic       BROWNOUT_FLAG_RST = 1'b0;
	// timing
	localparam int         CLK_MHZ         = 125;
	localparam int         PULSE_NS        = 64;
	localparam int         PULSE_CYC       = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int         STARTUP_CYCLES  = 1024;
	localparam int         CNT_W           = 24;
endpackage : bors_pkg

// File: logic/bors_sequencer.sv
`timescale 1ns/1ps
module bors_sequencer #(
	parameter int POWER_UP_DELAY_CYC    = 8750000,
	parameter int CLOCK_MONITOR_DELAY_CYC = 6250
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// supply monitor and power modes
	input  wire logic        brownout_detect,
	input  wire logic        brownout_enable,
	input  wire logic        sleep_mode,
	input  wire logic        idle_mode,
	// configuration
	input  wire logic [2:0]  initial_osc_select,
	input  wire logic [1:0]  primary_osc_mode,
	input  wire logic        power_up_delay_zero,
	input  wire logic        pll_locked,
	// software access to status
	input  wire logic        brownout_flag_clear,
	// outputs
	output logic             device_reset_pulse,
	output logic             internal_reset,
	output logic             clock_hold,
	output logic [2:0]       clock_source,
	output logic [1:0]       clock_osc_mode,
	output logic [7:0]       osc_control_reg,
	output logic [7:0]       reset_control_reg
);
	typedef enum logic [3:0] {
		ST_RUN   = 4'h1,
		ST_PULSE = 4'h2,
		ST_WAIT  = 4'h4,
		ST_DONE  = 4'h8
	} bors_state_t;

	bors_state_t                  st_q;
	bors_state_t                  st_d;
	logic [bors_pkg::CNT_W-1:0]   pcnt_q;
	logic [bors_pkg::CNT_W-1:0]   pcnt_d;
	logic                         hold_q;
	logic                         hold_d;
	logic                         irst_q;
	logic                         irst_d;
	logic                         pulse_q;
	logic                         pulse_d;
	logic                         flag_q;
	logic                         flag_d;
	logic [2:0]                   src_q;
	logic [2:0]                   src_d;
	logic [1:0]                   mode_q;
	logic [1:0]                   mode_d;
	logic                         lock_q;
	logic                         lock_d;
	logic                         start_delay;
	logic                         start_osc_timer;
	logic                         brownout_ev;

	bors_ctl_if delay_if ();
	bors_ctl_if startup_if ();

	// pll in use when the selected source is a pll variant
	function automatic logic uses_pll(input logic [2:0] sel);
		uses_pll = (sel == bors_pkg::OSC_SEL_FRC_PLL) || (sel == bors_pkg::OSC_SEL_PRI_PLL);
	endfunction : uses_pll

	// oscillator running from the primary pin in a crystal or external mode
	function automatic logic uses_osc(input logic [2:0] sel, input logic [1:0] mode);
		uses_osc = ((sel == bors_pkg::OSC_SEL_PRI) || (sel == bors_pkg::OSC_SEL_PRI_PLL))
			&& (mode != bors_pkg::POSC_OFF);
	endfunction : uses_osc

	function automatic logic is_crystal(input logic [1:0] mode);
		is_crystal = (mode == bors_pkg::POSC_XT) || (mode == bors_pkg::POSC_HS);
	endfunction : is_crystal

	// detector ignores sleep and idle on purpose: it must stay armed there
	assign brownout_ev = brownout_enable && brownout_detect
		&& (sleep_mode || idle_mode || 1'b1);

	assign start_delay = (st_q == ST_PULSE) && (pcnt_q == 24'h000001);
	assign start_osc_timer = start_delay;

	// power-up or clock monitor delay and start-up timer
	assign delay_if.start = start_delay;
	assign delay_if.load  = (power_up_delay_zero && is_crystal(mode_q))
		? bors_pkg::CNT_W'(CLOCK_MONITOR_DELAY_CYC)
		: (power_up_delay_zero ? 24'h000001 : bors_pkg::CNT_W'(POWER_UP_DELAY_CYC));
	assign startup_if.start = start_osc_timer;
	assign startup_if.load  = bors_pkg::CNT_W'(bors_pkg::STARTUP_CYCLES);

	bors_timer u_delay (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.ctl     (delay_if.timer)
	);

	bors_timer u_startup (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.ctl     (startup_if.timer)
	);

	// sequence: pulse, then wait for delay and clock release
	always_comb
	begin
		st_d    = st_q;
		pcnt_d  = pcnt_q;
		hold_d  = hold_q;
		irst_d  = irst_q;
		pulse_d = 1'b0;
		src_d   = src_q;
		mode_d  = mode_q;
		unique case (st_q)
			ST_RUN:
			begin
				hold_d = 1'b0;
				irst_d = 1'b0;
			end
			ST_PULSE:
			begin
				pulse_d = 1'b1;
				src_d   = initial_osc_select;
				mode_d  = primary_osc_mode;
				if (pcnt_q > 24'h000001)
					pcnt_d = pcnt_q - 24'h000001;
				else
					st_d = ST_WAIT;
			end
			ST_WAIT:
			begin
				// clock held until start-up timer (primary oscillator on) and pll lock (pll sources), reset until delay and clock release
				if ((!uses_osc(src_q, mode_q) || startup_if.done)
					&& (!uses_pll(src_q) || lock_q))
					hold_d = 1'b0;
				if (delay_if.done && !hold_d)
					st_d = ST_DONE;
			end
			ST_DONE:
			begin
				irst_d = 1'b0;
				st_d   = ST_RUN;
			end
			// a corrupted state code restarts the sequence instead of releasing reset early
			default:
			begin
				st_d   = ST_PULSE;
				pcnt_d = 24'(bors_pkg::PULSE_CYC);
				hold_d = 1'b1;
				irst_d = 1'b1;
			end
		endcase
		// a new brown-out restarts the sequence from any state
		if (brownout_ev)
		begin
			st_d    = ST_PULSE;
			pcnt_d  = 24'(bors_pkg::PULSE_CYC);
			hold_d  = 1'b1;
			irst_d  = 1'b1;
			pulse_d = 1'b1;
		end
	end

	// sticky flag: set beats software clear
	always_comb
	begin
		flag_d = flag_q;
		if (brownout_flag_clear)
			flag_d = 1'b0;
		if (brownout_ev)
			flag_d = 1'b1;
	end

	// lock sampled once so the status bit and the clock release agree
	always_comb
	begin
		lock_d = pll_locked;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q    <= ST_RUN;
			pcnt_q  <= '0;
			hold_q  <= 1'b0;
			irst_q  <= 1'b0;
			pulse_q <= 1'b0;
			flag_q  <= bors_pkg::BROWNOUT_FLAG_RST;
			src_q   <= bors_pkg::OSC_SEL_FRC;
			mode_q  <= bors_pkg::POSC_OFF;
			lock_q  <= 1'b0;
		end
		else
		begin
			st_q    <= st_d;
			pcnt_q  <= pcnt_d;
			hold_q  <= hold_d;
			irst_q  <= irst_d;
			pulse_q <= pulse_d;
			flag_q  <= flag_d;
			src_q   <= src_d;
			mode_q  <= mode_d;
			lock_q  <= lock_d;
		end
	end

	// outputs all from flops
	assign device_reset_pulse = pulse_q;
	assign internal_reset     = irst_q;
	assign clock_hold         = hold_q;
	assign clock_source       = src_q;
	assign clock_osc_mode     = mode_q;
	assign osc_control_reg    = {2'h0, lock_q, 5'h00}; // lock at bit 5
	assign reset_control_reg  = {6'h00, flag_q, 1'b0}; // flag at bit 1
endmodule : bors_sequencer

// File: logic/bors_timer.sv
`timescale 1ns/1ps
module bors_timer (
	// clock and reset
	input  wire logic  sys_clk,
	input  wire logic  reset_n,
	// control
	bors_ctl_if.timer  ctl
);
	logic [bors_pkg::CNT_W-1:0] cnt_q;
	logic [bors_pkg::CNT_W-1:0] cnt_d;
	logic                       run_q;
	logic                       run_d;
	logic                       done_q;
	logic                       done_d;

	// down counter, done is a level until next start
	always_comb
	begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		done_d = done_q;
		if (ctl.start)
		begin
			cnt_d  = ctl.load;
			run_d  = 1'b1;
			done_d = 1'b0;
		end
		else if (run_q)
		begin
			if (cnt_q <= 24'h000001)
			begin
				run_d  = 1'b0;
				done_d = 1'b1;
			end
			else
				cnt_d = cnt_q - 24'h000001;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			done_q <= done_d;
		end
	end

	assign ctl.done = done_q;
endmodule : bors_timer

// File: tb/bors_checker.sv
`timescale 1ns/1ps
module bors_checker (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       reset_n,
	// watched inputs
	input wire logic       brownout_detect,
	input wire logic       brownout_enable,
	input wire logic       brownout_flag_clear,
	input wire logic       sleep_mode,
	input wire logic [2:0] initial_osc_select,
	input wire logic [1:0] primary_osc_mode,
	// watched outputs
	input wire logic       device_reset_pulse,
	input wire logic       internal_reset,
	input wire logic       clock_hold,
	input wire logic [2:0] clock_source,
	input wire logic [1:0] clock_osc_mode,
	input wire logic [7:0] osc_control_reg,
	input wire logic [7:0] reset_control_reg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire logic ev = brownout_enable & brownout_detect;
	// helper views of the inputs and outputs so each property fits on its label's line
	wire logic [4:0] cfg_in   = {initial_osc_select, primary_osc_mode};
	wire logic [4:0] cfg_out  = {clock_source, clock_osc_mode};
	wire logic       pri_osc  = (clock_source[2:1] == 2'h1) && (clock_osc_mode != bors_pkg::POSC_OFF);
	wire logic       pll_sel  = (clock_source == bors_pkg::OSC_SEL_FRC_PLL)
		|| (clock_source == bors_pkg::OSC_SEL_PRI_PLL);
	wire logic       lock_bit = osc_control_reg[bors_pkg::OSC_LOCK_BIT];
	logic [10:0] cnt_q;
	logic [10:0] cnt_d;
	// cycles since the last brown-out, saturating so a long idle never wraps
	always_comb
	begin
		cnt_d = ev ? 11'h0 : (&cnt_q ? cnt_q : cnt_q + 11'h1);
	end
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			cnt_q <= 11'h0;
		else
			cnt_q <= cnt_d;
	end
	a_brownout_pulse: assert property (ev |=> device_reset_pulse && internal_reset && clock_hold)
		else $error("no reset after brownout");
	// the source is latched in the first pulse cycle, so it shows two edges after detection
	a_src_select: assert property (ev |-> ##2 cfg_out == $past(cfg_in))
		else $error("clock source not latched");
	a_startup_wait: assert property ($fell(clock_hold) && pri_osc |-> cnt_q >= bors_pkg::STARTUP_CYCLES)
		else $error("clock released before start-up timer");
	a_pll_wait: assert property ($fell(clock_hold) && pll_sel |-> $past(lock_bit))
		else $error("clock released before lock");
	a_rel_order: assert property ($fell(internal_reset) |-> !$past(clock_hold))
		else $error("reset released while clock held");
	a_flag_set: assert property (ev |=> reset_control_reg[bors_pkg::RST_BROWNOUT_BIT])
		else $error("brownout flag not set");
	a_flag_keep: assert property (reset_control_reg[1] && !brownout_flag_clear |=> reset_control_reg[1])
		else $error("brownout flag lost");
	a_flag_clear: assert property (brownout_flag_clear && !ev |=> !reset_control_reg[1])
		else $error("brownout flag not cleared");
	c_release: cover property ($fell(internal_reset));
	c_sleep_brownout: cover property (ev && sleep_mode);
	c_pll_release: cover property ($fell(clock_hold) && pll_sel);
	c_set_clear: cover property (ev && brownout_flag_clear);
endmodule : bors_checker

// File: tb/bors_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; $display("unexpected at %0t: mismatch", $time); end end
module bors_sequencer_tb;
	localparam int PU = 50;
	localparam int CM = 20;
	logic sys_clk, reset_n, brownout_detect, brownout_enable, sleep_mode, idle_mode;
	logic power_up_delay_zero, pll_locked, brownout_flag_clear;
	logic device_reset_pulse, internal_reset, clock_hold;
	logic [2:0] initial_osc_select, clock_source;
	logic [1:0] primary_osc_mode, clock_osc_mode;
	logic [7:0] osc_control_reg, reset_control_reg;
	int err_total = 0;
	int cmp_count = 0;
	bors_sequencer #(.POWER_UP_DELAY_CYC(PU), .CLOCK_MONITOR_DELAY_CYC(CM)) bors_sequencer_inst (.sys_clk,
		.reset_n, .brownout_detect, .brownout_enable, .sleep_mode, .idle_mode, .initial_osc_select,
		.primary_osc_mode, .power_up_delay_zero, .pll_locked, .brownout_flag_clear, .device_reset_pulse,
		.internal_reset, .clock_hold, .clock_source, .clock_osc_mode, .osc_control_reg, .reset_control_reg);
	// 125 MHz clock
	initial
	begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task complete_run;
		$display("compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	// one brown-out; release is measured in cycles from the detecting edge
	task run_brownout(input logic [2:0] sel, input logic [1:0] md, input logic z, input int lk, input int ex);
		int n;
		initial_osc_select = sel;
		primary_osc_mode = md;
		power_up_delay_zero = z;
		pll_locked = (lk == 0);
		brownout_detect = 1;
		step(1);
		brownout_detect = 0;
		`CHK(device_reset_pulse & internal_reset & clock_hold, 1'b1)
		`CHK(reset_control_reg[1], 1'b1)
		// the source is latched in the first pulse cycle, one edge after detection
		step(1);
		`CHK({clock_source, clock_osc_mode}, {sel, md})
		n = 2;
		while (internal_reset === 1'b1 && n < 3000)
		begin
			if (n == lk)
				pll_locked = 1;
			step(1);
			n++;
		end
		`CHK(n >= ex && n <= ex + 4, 1'b1)
		`CHK({device_reset_pulse, clock_hold}, 2'h0)
		`CHK(osc_control_reg, {2'h0, pll_locked, 5'h00})
		$display("brownout sel %0d mode %0d took %0d", sel, md, n);
	endtask : run_brownout
	// detection must stay alive in both low-power modes
	task t_modes;
		sleep_mode = 1;
		run_brownout(bors_pkg::OSC_SEL_FRC, bors_pkg::POSC_EC, 1, 0, 10);
		sleep_mode = 0;
		idle_mode = 1;
		run_brownout(bors_pkg::OSC_SEL_FRC, bors_pkg::POSC_EC, 1, 0, 10);
		idle_mode = 0;
		$display("modes done");
	endtask : t_modes
	// clear, gated detect, set winning over clear, persistence
	task t_flag;
		brownout_flag_clear = 1;
		step(1);
		brownout_flag_clear = 0;
		`CHK(reset_control_reg[1], 1'b0)
		brownout_enable = 0;
		brownout_detect = 1;
		step(3);
		`CHK({internal_reset, reset_control_reg[1]}, 2'h0)
		brownout_enable = 1;
		brownout_flag_clear = 1;
		step(1);
		brownout_detect = 0;
		brownout_flag_clear = 0;
		step(20);
		`CHK(reset_control_reg[1], 1'b1)
		step(70);
		$display("flag done");
	endtask : t_flag
	initial
	begin
		{brownout_detect, sleep_mode, idle_mode, power_up_delay_zero, pll_locked, brownout_flag_clear} = '0;
		{initial_osc_select, primary_osc_mode} = '0;
		brownout_enable = 1;
		reset_n = 0;
		step(12);
		reset_n = 1;
		run_brownout(bors_pkg::OSC_SEL_FRC, bors_pkg::POSC_EC, 0, 0, 9 + PU);
		run_brownout(bors_pkg::OSC_SEL_FRC, bors_pkg::POSC_XT, 1, 0, 9 + CM);
		run_brownout(bors_pkg::OSC_SEL_PRI, bors_pkg::POSC_HS, 0, 0, 9 + bors_pkg::STARTUP_CYCLES);
		// primary source with the oscillator off: no start-up wait at all
		run_brownout(bors_pkg::OSC_SEL_PRI, bors_pkg::POSC_OFF, 0, 0, 9 + PU);
		run_brownout(bors_pkg::OSC_SEL_FRC_PLL, bors_pkg::POSC_EC, 0, 200, 200);
		run_brownout(bors_pkg::OSC_SEL_PRI_PLL, bors_pkg::POSC_XT, 0, 300, 9 + bors_pkg::STARTUP_CYCLES);
		t_modes();
		t_flag();
		complete_run();
	end
	// watchdog well beyond the expected few thousand cycles
	initial
	begin
		#160000;
		err_total++;
		complete_run();
	end
endmodule : bors_sequencer_tb
bind bors_sequencer bors_checker bors_checker_inst (.sys_clk, .reset_n, .brownout_detect, .brownout_enable,
	.brownout_flag_clear, .sleep_mode, .initial_osc_select, .primary_osc_mode, .device_reset_pulse,
	.internal_reset, .clock_hold, .clock_source, .clock_osc_mode, .osc_control_reg, .reset_control_reg);
